// ---- rtl/nvs_seq_host.sv ----
// host controller issuing six-read soft sequences to a nonvolatile sram
// assumes store_busy_n and low_voltage are synchronous to clk_sys
// Operation
// - five lead reads then 0x0B45 disable the automatic power-loss save.
// - five lead reads then 0x0B46 re-enable the automatic power-loss save.
// - each step may be a chip-enable or output-enable controlled read.
// - a changed autosave setting persists only after a later store is issued.
// - the six addresses go out as consecutive accesses in exact order.
// - write enable stays high through all six accesses.
// - any other access inside a sequence aborts it.
`timescale 1ns/10ps
module nvs_seq_host (
	// clock and reset
	input  wire logic                            clk_sys,
	input  wire logic                            sys_rst,
	// user command port
	input  wire logic                            cmd_valid,
	input  wire logic [1:0]                      cmd_op,
	output logic                                 cmd_ready,
	output logic                                 cmd_done,
	output logic                                 cmd_aborted,
	output logic                                 save_dirty,
	// device status
	input  wire logic                            store_busy_n,
	input  wire logic                            low_voltage,
	// sram port
	output logic [nvs_seq_pkg::ADDR_W-1:0]       address_lines,
	output logic                                 ce_n,
	output logic                                 oe_n,
	output logic                                 we_n,
	input  wire logic [nvs_seq_pkg::DATA_W-1:0]  dq_in,
	output logic [nvs_seq_pkg::DATA_W-1:0]       dq_out,
	output logic                                 dq_oe,
	output logic [nvs_seq_pkg::DATA_W-1:0]       rd_data
);
	import nvs_seq_pkg::*;

	function automatic logic [ADDR_W-1:0] step_addr(input logic [2:0] s, input logic [1:0] op);
		logic [ADDR_W-1:0] a;
		a = SEQ_A0;
		case (s)
			3'h0: a = SEQ_A0;
			3'h1: a = SEQ_A1;
			3'h2: a = SEQ_A2;
			3'h3: a = SEQ_A3;
			3'h4: a = SEQ_A4;
			default: begin
				case (op)
					OP_AUTO_OFF: a = CMD_AUTO_OFF;
					OP_AUTO_ON:  a = CMD_AUTO_ON;
					OP_STORE:    a = CMD_STORE;
					default:     a = CMD_RECALL;
				endcase
			end
		endcase
		return a;
	endfunction : step_addr

	state_t            st_q, st_d;
	logic [2:0]        step_q, step_d;
	logic [1:0]        op_q, op_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic              ce_q, ce_d;
	logic              oe_q, oe_d;
	logic              use_oe_q, use_oe_d;
	logic              done_q, done_d;
	logic              abort_q, abort_d;
	logic              dirty_q, dirty_d;
	logic [DATA_W-1:0] rd_q, rd_d;
	logic              nv_cycle;

	assign nv_cycle = (op_q == OP_STORE) || (op_q == OP_RECALL);

	always_comb begin
		st_d     = st_q;
		step_d   = step_q;
		op_d     = op_q;
		cnt_d    = cnt_q;
		addr_d   = addr_q;
		ce_d     = ce_q;
		oe_d     = oe_q;
		use_oe_d = use_oe_q;
		done_d   = 1'b0;
		abort_d  = 1'b0;
		dirty_d  = dirty_q;
		rd_d     = rd_q;
		case (st_q)
			S_IDLE: begin
				if (cmd_valid) begin
					op_d   = cmd_op;
					step_d = 3'h0;
					addr_d = step_addr(3'h0, cmd_op);
					st_d   = S_SETUP;
				end
			end
			S_SETUP: begin
				if (low_voltage || !store_busy_n) begin
					abort_d = 1'b1;
					ce_d    = 1'b1;
					oe_d    = 1'b1;
					st_d    = S_IDLE;
				end else begin
					if (use_oe_q) begin
						ce_d = 1'b0;
						oe_d = 1'b1;
					end else begin
						ce_d = 1'b1;
						oe_d = 1'b0;
					end
					st_d  = S_ACC;
					cnt_d = CNT_W'(ACC_CYC);
				end
			end
			S_ACC: begin
				if (use_oe_q)
					oe_d = 1'b0;
				else
					ce_d = 1'b0;
				if (cnt_q != '0) begin
					cnt_d = cnt_q - CNT_W'(1);
				end else begin
					rd_d  = dq_in;
					ce_d  = 1'b1;
					oe_d  = 1'b1;
					cnt_d = CNT_W'(GAP_CYC);
					st_d  = S_GAP;
				end
			end
			S_GAP: begin
				if (cnt_q != '0) begin
					cnt_d = cnt_q - CNT_W'(1);
				end else if (step_q == STEP_LAST) begin
					if (op_q == OP_AUTO_OFF || op_q == OP_AUTO_ON)
						dirty_d = 1'b1;
					else if (op_q == OP_STORE)
						dirty_d = 1'b0;
					st_d = nv_cycle ? S_BUSY : S_IDLE;
					done_d = !nv_cycle;
				end else begin
					step_d   = step_q + 3'h1;
					// full address out, low bits matter
					addr_d   = step_addr(step_q + 3'h1, op_q);
					use_oe_d = !use_oe_q;
					st_d     = S_SETUP;
				end
			end
			S_BUSY: begin
				if (store_busy_n) begin
					cnt_d = CNT_W'(RELEASE_CYC);
					st_d  = S_HOLD;
				end
			end
			S_HOLD: begin
				if (!store_busy_n) begin
					st_d = S_BUSY;
				end else if (cnt_q != '0) begin
					cnt_d = cnt_q - CNT_W'(1);
				end else begin
					done_d = 1'b1;
					st_d   = S_IDLE;
				end
			end
			default: st_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q     <= S_IDLE;
			step_q   <= '0;
			op_q     <= '0;
			cnt_q    <= '0;
			addr_q   <= '0;
			ce_q     <= 1'b1;
			oe_q     <= 1'b1;
			use_oe_q <= 1'b0;
			done_q   <= 1'b0;
			abort_q  <= 1'b0;
			dirty_q  <= 1'b0;
			rd_q     <= '0;
		end else begin
			st_q     <= st_d;
			step_q   <= step_d;
			op_q     <= op_d;
			cnt_q    <= cnt_d;
			addr_q   <= addr_d;
			ce_q     <= ce_d;
			oe_q     <= oe_d;
			use_oe_q <= use_oe_d;
			done_q   <= done_d;
			abort_q  <= abort_d;
			dirty_q  <= dirty_d;
			rd_q     <= rd_d;
		end
	end

	assign cmd_ready     = (st_q == S_IDLE);
	assign cmd_done      = done_q;
	assign cmd_aborted   = abort_q;
	assign save_dirty    = dirty_q;
	assign address_lines = addr_q;
	assign ce_n          = ce_q;
	assign oe_n          = oe_q;
	// write enable held high; no interleaved access
	assign we_n          = 1'b1;
	assign dq_out        = '0;
	assign dq_oe         = 1'b0;
	assign rd_data       = rd_q;
endmodule : nvs_seq_host

// ---- rtl/nvs_seq_pkg.sv ----
// constants for the host-side soft-sequence controller of a nonvolatile sram
// assumes a 25 MHz system clock and a 17-bit asynchronous sram port
package nvs_seq_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int CMP_W  = 14;
	localparam int SEQ_LEN = 6;
	localparam logic [ADDR_W-1:0] SEQ_A0 = 17'h04E38;
	localparam logic [ADDR_W-1:0] SEQ_A1 = 17'h0B1C7;
	localparam logic [ADDR_W-1:0] SEQ_A2 = 17'h083E0;
	localparam logic [ADDR_W-1:0] SEQ_A3 = 17'h07C1F;
	localparam logic [ADDR_W-1:0] SEQ_A4 = 17'h0703F;
	localparam logic [ADDR_W-1:0] CMD_AUTO_OFF = 17'h00B45;
	localparam logic [ADDR_W-1:0] CMD_AUTO_ON  = 17'h00B46;
	localparam logic [ADDR_W-1:0] CMD_STORE    = 17'h00FC0;
	localparam logic [ADDR_W-1:0] CMD_RECALL   = 17'h00C63;
	// command codes on the user port
	localparam logic [1:0] OP_AUTO_OFF = 2'h0;
	localparam logic [1:0] OP_AUTO_ON  = 2'h1;
	localparam logic [1:0] OP_STORE    = 2'h2;
	localparam logic [1:0] OP_RECALL   = 2'h3;
	// timing
	localparam int CLK_MHZ      = 25;
	localparam int ACC_NS       = 80;
	localparam int ACC_CYC      = (ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_NS       = 40;
	localparam int GAP_CYC      = (GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int RELEASE_NS   = 200;
	localparam int RELEASE_CYC  = (RELEASE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W        = 8;
	localparam logic [2:0] STEP_LAST = 3'h5;
	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_ACC, S_GAP, S_BUSY, S_HOLD} state_t;
endpackage : nvs_seq_pkg

// ---- test/nvs_dev_model.sv ----
// behavioural nonvolatile sram: sequence decoder and busy flag
// assumes strobes are sampled on the host clock
`timescale 1ns/10ps
module nvs_dev_model (
	input wire logic        clk_sys, ce_n, oe_n, we_n, low_voltage,
	input wire logic [16:0] address_lines,
	output logic [7:0]      dq_in,
	output logic            store_busy_n,
	output logic            autosave = 1'b1,
	output int              stores = 0
);
	import nvs_seq_pkg::*;
	logic [13:0] tbl [5] = '{SEQ_A0[13:0], SEQ_A1[13:0], SEQ_A2[13:0], SEQ_A3[13:0], SEQ_A4[13:0]};
	logic [13:0] a_q = 14'h0000;
	logic [13:0] a;
	logic [7:0]  pat = 8'hA5;
	logic        act, act_q = 1'b0;
	int          step = 0, bcnt = 0;
	assign a = address_lines[13:0];
	// a read needs both enables low; the later one times it
	assign act = !ce_n && !oe_n;
	assign store_busy_n = (bcnt == 0);
	// cells read zero; hi-z shown as a moving pattern
	assign dq_in = (act && !(step == 5 && (a == CMD_STORE[13:0] || a == CMD_RECALL[13:0]))) ?
		8'h00 : pat;
	always @(posedge clk_sys) begin
		act_q <= act;
		pat <= ~pat;
		if (act) a_q <= a;
		if (bcnt != 0) bcnt <= bcnt - 1;
		if (act_q && !act) begin
			step <= (step < 5 && a_q == tbl[step]) ? step + 1 : int'(a_q == tbl[0]);
			if (step == 5) begin
				if (a_q == CMD_AUTO_OFF[13:0]) autosave <= 1'b0;
				if (a_q == CMD_AUTO_ON[13:0]) autosave <= 1'b1;
				if (a_q == CMD_RECALL[13:0]) bcnt <= 8;
				if (a_q == CMD_STORE[13:0] && !low_voltage) begin
					bcnt <= 8;
					stores <= stores + 1;
				end
			end
		end
		if (!we_n) step <= 0;
	end
endmodule : nvs_dev_model

// ---- test/nvs_seq_host_checker.sv ----
// port assertions for the host soft-sequence controller
// assumes it is bound onto every nvs_seq_host instance
`timescale 1ns/10ps
module nvs_seq_host_checker (
	input wire logic                      clk_sys, sys_rst, cmd_valid, cmd_ready,
	input wire logic                      cmd_done, cmd_aborted, low_voltage, store_busy_n,
	input wire logic                      ce_n, oe_n, we_n, dq_oe,
	input wire logic [nvs_seq_pkg::ADDR_W-1:0] address_lines
);
	import nvs_seq_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_take; cmd_ready && cmd_valid && !low_voltage && store_busy_n; endsequence
	sequence s_strobe; $fell(ce_n && oe_n); endsequence
	property p_we_high; we_n; endproperty
	a_we_high: assert property (p_we_high) else $error("write strobe low");
	property p_no_drive; !dq_oe; endproperty
	a_no_drive: assert property (p_no_drive) else $error("host drives data");
	property p_one_strobe; !($fell(ce_n) && $fell(oe_n)); endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("both strobes fell");
	property p_first; s_take |=> ##[0:2] address_lines[13:0] == SEQ_A0[13:0]; endproperty
	a_first: assert property (p_first) else $error("first address wrong");
	property p_hold; !(ce_n && oe_n) |=> (ce_n && oe_n) || $stable(address_lines); endproperty
	a_hold: assert property (p_hold) else $error("address moved in strobe");
	property p_ce_w; $fell(ce_n) |-> !ce_n [*2]; endproperty
	a_ce_w: assert property (p_ce_w) else $error("chip strobe short");
	property p_low; cmd_ready && cmd_valid && low_voltage |-> ##[1:3] cmd_aborted; endproperty
	a_low: assert property (p_low) else $error("low supply not aborted");
	property p_idle; cmd_done |-> ce_n && oe_n; endproperty
	a_idle: assert property (p_idle) else $error("strobe at done");
	property p_busy; s_strobe |-> $past(store_busy_n); endproperty
	a_busy: assert property (p_busy) else $error("access while busy");
endmodule : nvs_seq_host_checker
bind nvs_seq_host nvs_seq_host_checker u_chk (.*);

// ---- test/tb_top.sv ----
// self-checking bench for the host soft-sequence controller
// assumes the device model stands on the sram port
`timescale 1ns/10ps
module tb_top;
	import nvs_seq_pkg::*;
	logic clk_sys = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, low_voltage = 1'b0, got_abort;
	logic [1:0] cmd_op = 2'h0;
	logic cmd_ready, cmd_done, cmd_aborted, save_dirty, store_busy_n, ce_n, oe_n, we_n, dq_oe;
	logic autosave;
	logic [ADDR_W-1:0] address_lines;
	logic [DATA_W-1:0] dq_in, dq_out, rd_data;
	int stores, bad_count = 0, checks_done = 0;
	nvs_seq_host dut (.*);
	nvs_dev_model dev (.*);
	always #20 clk_sys = ~clk_sys;
	task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %0t %s", $time, m);
		end
	endtask : chk
	task chk_bit(input logic got, input logic exp, input string m);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %0t %s", $time, m);
		end
	endtask : chk_bit
	task run(input logic [1:0] op);
		int i;
		@(posedge clk_sys) #1 cmd_valid = 1'b1;
		cmd_op = op;
		@(posedge clk_sys) #1 cmd_valid = 1'b0;
		for (i = 0; i < 300 && cmd_done !== 1'b1 && cmd_aborted !== 1'b1; i++) @(posedge clk_sys) #1;
		got_abort = cmd_aborted;
		if (cmd_done !== 1'b1 && cmd_aborted !== 1'b1) begin
			bad_count++;
			$display("wrong value %0t %s", $time, "no command answer");
		end
	endtask : run
	task t_modes;
		chk_bit(autosave, 1'b1, "autosave default");
		run(OP_AUTO_OFF);
		chk_bit(autosave, 1'b0, "autosave off");
		chk_bit(save_dirty, 1'b1, "dirty set");
		chk(rd_data, 8'h00, "cell data");
		chk_bit(cmd_ready, 1'b1, "ready after done");
		run(OP_AUTO_ON);
		chk_bit(autosave, 1'b1, "autosave on");
		run(OP_STORE);
		chk(8'(stores), 8'h01, "store count");
		chk_bit(save_dirty, 1'b0, "dirty cleared");
		run(OP_RECALL);
		chk_bit(got_abort, 1'b0, "recall done");
		run(OP_STORE);
		chk(8'(stores), 8'h02, "store again");
	endtask : t_modes
	task t_low;
		low_voltage = 1'b1;
		run(OP_STORE);
		chk_bit(got_abort, 1'b1, "abort on low");
		chk(8'(stores), 8'h02, "no store");
		low_voltage = 1'b0;
	endtask : t_low
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		#1 sys_rst = 0;
		t_modes;
		t_low;
		tally_and_finish;
	end
endmodule : tb_top
